// *** dv/analog_source_model.sv ***
// Purpose: comparator and input sources seen by the sequencer
// Assumes: input n holds code {n,n}; gate off feeds the external level
// Notes:   ideal comparator, so the result equals the source code
`timescale 1ns/1ps
`default_nettype none
module analog_source_model
    import sar_adc_pkg::*;
(
    input  wire logic [CHAN_N-1:0]   mux_select,
    input  wire logic [RESULT_W-1:0] ladder_code,
    input  wire logic [RESULT_W-1:0] ext_level,
    output logic                     comp_above
);
    logic [RESULT_W-1:0] level;
    always_comb begin
        // all switches open: the external source reaches the comparator
        level = ext_level;
        for (int i = 0; i < CHAN_N; i++) begin
            if (mux_select[i]) begin
                level = {i[3:0], i[3:0]};
            end
        end
        comp_above = (level >= ladder_code);
    end
endmodule : analog_source_model
`default_nettype wire

// *** dv/sar_adc_mux_sequencer_tb.sv ***
// Purpose: self-checking bench for the converter sequencer
// Assumes: step divider shortened to 8 to keep the run short
// Notes:   rows of channel, selection and code, then hand tests
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module sar_adc_mux_sequencer_tb
    import sar_adc_pkg::*;
;
    localparam int unsigned DIV = 8;
    typedef struct packed {
        logic [3:0]  ch;
        logic [15:0] sel;
        logic [7:0]  res;
    } row_s;
    localparam row_s ROWS [6] = '{'{4'h9, 16'h0200, 8'h99},
        '{4'hF, 16'h8000, 8'hFF}, '{4'h0, 16'h0001, 8'h00},
        '{4'h5, 16'h0020, 8'h55}, '{4'hA, 16'h0400, 8'hAA},
        '{4'h3, 16'h0008, 8'h33}};
    logic mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic strobe = 1'b0, gate = 1'b1, trig = 1'b0, oe = 1'b1;
    logic [7:0] adr = 8'h00, ext = 8'h3C;
    logic [31:0] wdat = 32'h0, rd, dat_o;
    logic [3:0] sel = 4'h0, chan = 4'h0;
    logic ack, done, comp;
    logic [15:0] mux;
    logic [7:0] ladder, dout, oe_n;
    int bad_count = 0;
    int compares = 0;
    always #5 mclk = ~mclk;
    sar_adc_mux_sequencer #(.STEP_DIV(DIV)) u_dut (
        .MCLK(mclk), .RST(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
        .ADR_I(adr), .DAT_I(wdat), .SEL_I(sel), .DAT_O(dat_o), .ACK_O(ack),
        .ADDR_STROBE(strobe), .CHAN_ADDR(chan), .INPUT_GATE(gate),
        .CONVERSION_TRIGGER(trig), .OUTPUT_ENABLE(oe), .COMP_ABOVE(comp),
        .MUX_SELECT(mux), .LADDER_CODE(ladder), .CONVERSION_DONE(done),
        .DATA_OUT(dout), .DATA_OE_N(oe_n));
    analog_source_model u_src (.mux_select(mux), .ladder_code(ladder),
        .ext_level(ext), .comp_above(comp));
    task automatic summarize();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
        // no cycle count assumed; the watchdog ends a hung wait
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge mclk);
    endtask : wb
    task automatic latch(input logic [3:0] c);
        @(posedge mclk);
        chan <= c;
        tick(3);
        strobe <= 1'b1;
        tick(4);
        strobe <= 1'b0;
        tick(5);
    endtask : latch
    task automatic pulse();
        @(posedge mclk);
        trig <= 1'b1;
        tick(8 * DIV + 200);
        trig <= 1'b0;
    endtask : pulse
    task automatic conv();
        int n;
        n = 0;
        fork
            pulse();
            while (done !== 1'b0 && n < 8 * DIV) begin
                @(posedge mclk);
                n++;
            end
        join_any
        `CHK(done, 1'b0)
        wait fork;
        n = 0;
        while (done !== 1'b1 && n < 12 * DIV) begin
            @(posedge mclk);
            n++;
        end
        `CHK(done, 1'b1)
        tick(2);
    endtask : conv
    initial begin
        int n;
        logic prev;
        tick(6);
        rst <= 1'b0;
        tick(4);
        foreach (ROWS[i]) begin
            latch(ROWS[i].ch);
            `CHK(mux, ROWS[i].sel)
            conv();
            `CHK(dout, ROWS[i].res)
            `CHK(oe_n, 8'h00)
            wb(1'b0, RESULT_OFS, 32'h0);
            `CHK(rd[7:0], ROWS[i].res)
            wb(1'b0, STATUS_OFS, 32'h0);
            `CHK(rd[7:4], ROWS[i].ch)
            $display("row %0d done", i);
        end
        gate <= 1'b0;
        tick(6);
        `CHK(mux, 16'h0000)
        conv();
        `CHK(dout, 8'h3C)
        gate <= 1'b1;
        chan <= 4'hE;
        tick(8);
        `CHK(mux, 16'h0008)
        $display("gate test done");
        latch(4'h2);
        pulse();
        tick(3 * DIV);
        `CHK(done, 1'b0)
        wb(1'b0, STATUS_OFS, 32'h0);
        `CHK(rd[1], 1'b1)
        latch(4'h7);
        conv();
        `CHK(dout, 8'h77)
        $display("abort test done");
        wb(1'b1, CTRL_OFS, 32'h2);
        pulse();
        n = 0;
        prev = done;
        repeat (40 * DIV) begin
            @(posedge mclk);
            if (done === 1'b1 && prev !== 1'b1) n++;
            prev = done;
        end
        `CHK(n >= 3, 1'b1)
        wb(1'b1, CTRL_OFS, 32'h0);
        tick(12 * DIV);
        `CHK(done, 1'b1)
        $display("free run test done");
        oe <= 1'b0;
        tick(5);
        `CHK(oe_n, 8'hFF)
        wb(1'b1, CTRL_OFS, 32'h4);
        tick(5);
        `CHK(oe_n, 8'h00)
        wb(1'b1, CTRL_OFS, 32'h0);
        oe <= 1'b1;
        wb(1'b1, 8'h0C, 32'hFF);
        wb(1'b0, 8'h0C, 32'h0);
        `CHK(rd, 32'h0)
        wb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rd, 32'h0)
        $display("enable and register test done");
        pulse();
        tick(2 * DIV);
        rst <= 1'b1;
        tick(2);
        `CHK(done, 1'b1)
        `CHK(dout, 8'h00)
        `CHK(oe_n, 8'hFF)
        `CHK(mux, 16'h0000)
        rst <= 1'b0;
        tick(4);
        wb(1'b0, STATUS_OFS, 32'h0);
        `CHK(rd[2:0], 3'h5)
        $display("reset test done");
        summarize();
    end
    // whole run is near 4300 cycles; give it ample margin
    initial begin
        #400000;
        bad_count++;
        summarize();
    end
endmodule : sar_adc_mux_sequencer_tb
`default_nettype wire

// *** dv/sar_adc_seq_monitor.sv ***
// Purpose: port checker for the converter sequencer
// Assumes: pins held steady for several MCLK around each change
// Notes:   windows allow for the 2-3 MCLK pin synchroniser delay
`timescale 1ns/1ps
`default_nettype none
module sar_adc_seq_monitor
    import sar_adc_pkg::*;
#(
    parameter int unsigned STEP_DIV = STEP_CYCLES
) (
    input wire logic                MCLK,
    input wire logic                RST,
    input wire logic                CYC_I,
    input wire logic                STB_I,
    input wire logic                ACK_O,
    input wire logic                ADDR_STROBE,
    input wire logic                INPUT_GATE,
    input wire logic                CONVERSION_TRIGGER,
    input wire logic                OUTPUT_ENABLE,
    input wire logic [CHAN_N-1:0]   MUX_SELECT,
    input wire logic [RESULT_W-1:0] LADDER_CODE,
    input wire logic                CONVERSION_DONE,
    input wire logic [RESULT_W-1:0] DATA_OUT,
    input wire logic [RESULT_W-1:0] DATA_OE_N
);
    // pin path needs about three cycles; the full step limit is too long
    localparam int DONE_WIN = 8;
    logic [RESULT_W-1:0] data_q, data_d;
    logic [15:0]         since_q, since_d;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    // cycles since the result register last changed, saturating
    always_comb begin
        data_d  = DATA_OUT;
        since_d = (DATA_OUT != data_q) ? 16'h0001 :
                  (since_q == 16'hFFFF) ? since_q : since_q + 16'h0001;
    end
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            data_q  <= RESULT_RESET;
            since_q <= 16'hFFFF;
        end else begin
            data_q  <= data_d;
            since_q <= since_d;
        end
    end
    sequence s_trig_held; CONVERSION_TRIGGER [*6]; endsequence
    sequence s_start; s_trig_held ##1 !CONVERSION_TRIGGER; endsequence
    property p_ack; CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O;
    endproperty
    property p_latch_hold;
        (!ADDR_STROBE && INPUT_GATE) [*6] |-> $stable(MUX_SELECT);
    endproperty
    property p_select; INPUT_GATE [*5] |-> $onehot(MUX_SELECT); endproperty
    property p_gate_off; !INPUT_GATE [*5] |-> MUX_SELECT == 16'h0000;
    endproperty
    property p_clear; s_trig_held |-> LADDER_CODE == 8'h00; endproperty
    property p_start; s_start |-> ##[1:6] LADDER_CODE == MSB_MASK;
    endproperty
    property p_done_low;
        $rose(CONVERSION_TRIGGER) |-> ##[1:DONE_WIN] !CONVERSION_DONE;
    endproperty
    // result unchanged gives no visible update, so only fresh ones count
    property p_update;
        $rose(CONVERSION_DONE) && since_q < 2 * STEP_DIV
            |-> since_q == STEP_DIV;
    endproperty
    property p_drive; OUTPUT_ENABLE [*5] |-> DATA_OE_N == 8'h00; endproperty
    a_ack: assert property (p_ack)
        else $error("bus ack not a single pulse");
    a_latch_hold: assert property (p_latch_hold)
        else $error("selection moved without strobe");
    a_select: assert property (p_select)
        else $error("gate high but selection not one-hot");
    a_gate_off: assert property (p_gate_off)
        else $error("gate low but an input is on");
    a_clear: assert property (p_clear)
        else $error("trial code not cleared while trigger high");
    a_start: assert property (p_start)
        else $error("sequence did not start on trigger fall");
    a_done_low: assert property (p_done_low)
        else $error("done not low after trigger rise");
    a_update: assert property (p_update)
        else $error("result not updated one step before done");
    a_drive: assert property (p_drive)
        else $error("data not driven with enable high");
endmodule : sar_adc_seq_monitor
bind sar_adc_mux_sequencer sar_adc_seq_monitor #(.STEP_DIV(STEP_DIV)) u_mon (
    .MCLK(MCLK), .RST(RST), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
    .ADDR_STROBE(ADDR_STROBE), .INPUT_GATE(INPUT_GATE),
    .CONVERSION_TRIGGER(CONVERSION_TRIGGER), .OUTPUT_ENABLE(OUTPUT_ENABLE),
    .MUX_SELECT(MUX_SELECT), .LADDER_CODE(LADDER_CODE),
    .CONVERSION_DONE(CONVERSION_DONE), .DATA_OUT(DATA_OUT),
    .DATA_OE_N(DATA_OE_N));
`default_nettype wire

// *** rtl/approx_register.sv ***
// Purpose: successive approximation register, one bit decision per step
// Assumes: comparator level is synchronised and settled at each step
// Notes:   trial code is registered so it can drive the ladder directly
`timescale 1ns/1ps
`default_nettype none
module approx_register
    import sar_adc_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                clear,
    input  wire logic                load,
    input  wire logic                step,
    input  wire logic                comp_above,
    output logic      [RESULT_W-1:0] trial_code,
    output logic      [RESULT_W-1:0] result,
    output logic                     last
);
    logic [RESULT_W-1:0] sar_q;
    logic [RESULT_W-1:0] sar_d;
    logic [RESULT_W-1:0] mask_q;
    logic [RESULT_W-1:0] mask_d;
    logic [RESULT_W-1:0] trial_q;
    logic [RESULT_W-1:0] trial_d;

    always_comb begin
        sar_d  = sar_q;
        mask_d = mask_q;
        if (clear) begin
            sar_d  = '0;
            mask_d = '0;
        end else if (load) begin
            sar_d  = '0;
            mask_d = MSB_MASK;
        end else if (step && (mask_q != '0)) begin
            // keep the trial bit only while input stays above it
            if (comp_above) begin
                sar_d = sar_q | mask_q;
            end
            mask_d = mask_q >> 1;
        end
        trial_d = sar_d | mask_d;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sar_q   <= '0;
            mask_q  <= '0;
            trial_q <= '0;
        end else begin
            sar_q   <= sar_d;
            mask_q  <= mask_d;
            trial_q <= trial_d;
        end
    end

    assign trial_code = trial_q;
    assign result     = sar_q;
    assign last       = (mask_q == '0);
endmodule : approx_register
`default_nettype wire

// *** rtl/sar_adc_mux_sequencer.sv ***
// Purpose: control of an 8-bit approximation converter with input selector
// Assumes: pins are asynchronous to MCLK; comparator is an external level
// Notes:   registers over classic Wishbone; pins and register bits combine
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE_01 - latch channel address on strobe rising edge
// RULE_02 - gate high selects input by address
// RULE_03 - gate low switches all inputs off
// RULE_04 - eight bit decisions, most significant first
// RULE_05 - trigger rising edge clears approximation register
// RULE_06 - trigger falling edge starts the sequence
// RULE_07 - new trigger aborts and restarts a conversion
// RULE_08 - done fed to trigger gives free running
// RULE_09 - host gives one trigger after power up
// RULE_10 - done drops within eight clocks of trigger
// RULE_11 - result is positive true binary
// RULE_12 - first step at half code, then full steps
// RULE_13 - data register loads one clock before done; the code loads it one step (STEP_DIV clocks) before done
// RULE_14 - data drives only while output enable asserted
// RULE_15 - host holds async trigger long enough
// RULE_16 - done returns high after last decision
module sar_adc_mux_sequencer
    import sar_adc_pkg::*;
#(
    parameter int unsigned STEP_DIV = STEP_CYCLES
) (
    input  wire logic                MCLK,
    input  wire logic                RST,
    input  wire logic                CYC_I,
    input  wire logic                STB_I,
    input  wire logic                WE_I,
    input  wire logic [ADR_W-1:0]    ADR_I,
    input  wire logic [31:0]         DAT_I,
    input  wire logic [3:0]          SEL_I,
    output logic      [31:0]         DAT_O,
    output logic                     ACK_O,
    input  wire logic                ADDR_STROBE,
    input  wire logic [CHAN_W-1:0]   CHAN_ADDR,
    input  wire logic                INPUT_GATE,
    input  wire logic                CONVERSION_TRIGGER,
    input  wire logic                OUTPUT_ENABLE,
    input  wire logic                COMP_ABOVE,
    output logic      [CHAN_N-1:0]   MUX_SELECT,
    output logic      [RESULT_W-1:0] LADDER_CODE,
    output logic                     CONVERSION_DONE,
    output logic      [RESULT_W-1:0] DATA_OUT,
    output logic      [RESULT_W-1:0] DATA_OE_N
);

    localparam int unsigned PIN_W = CHAN_W + 5;
    localparam int unsigned DIV_W = $clog2(STEP_DIV + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_DIV - 1);

    function automatic logic [CHAN_N-1:0] decode_chan(
        input logic             gate,
        input logic [CHAN_W-1:0] addr
    );
        logic [CHAN_N-1:0] onehot;
        onehot = '0;
        if (gate) begin
            onehot[addr] = 1'b1;
        end
        return onehot;
    endfunction : decode_chan

    // pin synchronisation
    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_s;
    logic             strobe_s;
    logic [CHAN_W-1:0] addr_s;
    logic             gate_s;
    logic             trig_pin_s;
    logic             oe_pin_s;
    logic             comp_s;

    assign pins_raw = {COMP_ABOVE, OUTPUT_ENABLE, CONVERSION_TRIGGER,
                       INPUT_GATE, CHAN_ADDR, ADDR_STROBE};

    sync_two_stage #(
        .WIDTH    (PIN_W)
    ) u_pin_sync (
        .clk      (MCLK),
        .rst      (RST),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    assign strobe_s   = pins_s[0];
    assign addr_s     = pins_s[CHAN_W:1];
    assign gate_s     = pins_s[CHAN_W+1];
    assign trig_pin_s = pins_s[CHAN_W+2];
    assign oe_pin_s   = pins_s[CHAN_W+3];
    assign comp_s     = pins_s[CHAN_W+4];

    // register file state
    logic [2:0]          ctrl_q;
    logic [2:0]          ctrl_d;
    logic                ack_q;
    logic                ack_d;
    logic [31:0]         rdata_q;
    logic [31:0]         rdata_d;

    // selector state
    logic                strobe_prev_q;
    logic                strobe_prev_d;
    logic [CHAN_W-1:0]   chan_q;
    logic [CHAN_W-1:0]   chan_d;
    logic [CHAN_N-1:0]   mux_q;
    logic [CHAN_N-1:0]   mux_d;

    // sequencer state
    seq_state_e          state_q;
    seq_state_e          state_d;
    logic                trig_prev_q;
    logic                trig_prev_d;
    logic [DIV_W-1:0]    div_q;
    logic [DIV_W-1:0]    div_d;
    logic                done_q;
    logic                done_d;
    logic [RESULT_W-1:0] result_q;
    logic [RESULT_W-1:0] result_d;
    logic [RESULT_W-1:0] oe_n_q;
    logic [RESULT_W-1:0] oe_n_d;

    logic                trig_level;
    logic                trig_rise;
    logic                trig_fall;
    logic                step_tick;
    logic                sar_clear;
    logic                sar_load;
    logic                sar_step;
    logic [RESULT_W-1:0] trial_code;
    logic [RESULT_W-1:0] sar_value;
    logic                sar_last;

    // bus access
    logic                bus_req;
    logic                bus_wr;

    assign bus_req = CYC_I && STB_I && !ack_q;
    assign bus_wr  = bus_req && WE_I;

    always_comb begin
        ctrl_d  = ctrl_q;
        ack_d   = bus_req;
        rdata_d = '0;
        if (bus_wr && SEL_I[0] && (ADR_I == CTRL_OFS)) begin
            ctrl_d = DAT_I[2:0];
        end
        if (bus_req && !WE_I) begin
            unique case (ADR_I)
                CTRL_OFS: begin
                    rdata_d[2:0] = ctrl_q;
                end
                STATUS_OFS: begin
                    rdata_d[STAT_DONE_BIT] = done_q;
                    rdata_d[STAT_BUSY_BIT] = (state_q != ST_IDLE);
                    rdata_d[STAT_GATE_BIT] = gate_s;
                    rdata_d[STAT_CHAN_LSB +: CHAN_W] = chan_q;
                end
                RESULT_OFS: begin
                    rdata_d[RESULT_W-1:0] = result_q;
                end
                // unmapped offsets read zero and still acknowledge
                default: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ctrl_q  <= CTRL_RESET;
            ack_q   <= 1'b0;
            rdata_q <= '0;
        end else begin
            ctrl_q  <= ctrl_d;
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // channel selection
    always_comb begin
        strobe_prev_d = strobe_s;
        chan_d        = chan_q;
        if (strobe_s && !strobe_prev_q) begin
            chan_d = addr_s; // RULE_01
        end
        // gate is live, the address only moves on a strobe edge
        mux_d = decode_chan(gate_s, chan_d); // RULE_02 RULE_03
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            strobe_prev_q <= 1'b0;
            chan_q        <= CHAN_RESET;
            mux_q         <= '0;
        end else begin
            strobe_prev_q <= strobe_prev_d;
            chan_q        <= chan_d;
            mux_q         <= mux_d;
        end
    end

    // trigger sources: pin, software bit, or own done in free running
    assign trig_level = trig_pin_s || ctrl_q[CTRL_TRIG_BIT]
                        || (ctrl_q[CTRL_FREE_BIT] && done_q); // RULE_08
    assign trig_rise  = trig_level && !trig_prev_q;
    assign trig_fall  = !trig_level && trig_prev_q;
    assign step_tick  = (div_q == DIV_LAST);

    // sequencer
    always_comb begin
        state_d     = state_q;
        trig_prev_d = trig_level;
        div_d       = step_tick ? '0 : div_q + 1'b1;
        done_d      = done_q;
        result_d    = result_q;
        sar_clear   = 1'b0;
        sar_load    = 1'b0;
        sar_step    = 1'b0;
        if (trig_rise) begin
            // any rising edge, running or not, clears the register and re-arms
            state_d   = ST_ARMED; // RULE_07
            sar_clear = 1'b1; // RULE_05
            done_d    = 1'b0; // RULE_10
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    state_d = ST_IDLE;
                end
                ST_ARMED: begin
                    if (trig_fall) begin
                        state_d  = ST_RUN; // RULE_06
                        sar_load = 1'b1;
                        div_d    = '0;
                    end
                end
                ST_RUN: begin
                    if (step_tick) begin
                        // comparator against ladder offset by half a code
                        sar_step = 1'b1; // RULE_04 RULE_12
                        if (sar_last) begin
                            state_d = ST_LATCH;
                        end
                    end
                end
                ST_LATCH: begin
                    if (step_tick) begin
                        state_d = ST_IDLE;
                        done_d  = 1'b1; // RULE_16
                    end
                end
            endcase
        end
        // result loads on entry to latch, one step before done rises
        if ((state_q == ST_RUN) && (state_d == ST_LATCH)) begin
            result_d = sar_value; // RULE_13
        end
        if (state_q == ST_RUN && step_tick && sar_last && !trig_rise) begin
            sar_step = 1'b0;
        end
        // drivers on, all bits low-active, while enable pin or control enable bit is set
        oe_n_d = (oe_pin_s || ctrl_q[CTRL_OE_BIT]) ? '0 : '1; // RULE_14
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_q     <= ST_IDLE;
            trig_prev_q <= 1'b0;
            div_q       <= '0;
            done_q      <= DONE_RESET;
            result_q    <= RESULT_RESET;
            oe_n_q      <= '1;
        end else begin
            state_q     <= state_d;
            trig_prev_q <= trig_prev_d;
            div_q       <= div_d;
            done_q      <= done_d;
            result_q    <= result_d;
            oe_n_q      <= oe_n_d;
        end
    end

    // step loads the eighth decision while sar_last is still low
    approx_register u_sar (
        .clk        (MCLK),
        .rst        (RST),
        .clear      (sar_clear),
        .load       (sar_load),
        .step       (sar_step),
        .comp_above (comp_s),
        .trial_code (trial_code),
        .result     (sar_value),
        .last       (sar_last)
    );

    assign DAT_O           = rdata_q;
    assign ACK_O           = ack_q;
    assign MUX_SELECT      = mux_q;
    assign LADDER_CODE     = trial_code;
    assign CONVERSION_DONE = done_q;
    assign DATA_OUT        = result_q; // RULE_11
    assign DATA_OE_N       = oe_n_q;

endmodule : sar_adc_mux_sequencer
`default_nettype wire

// *** rtl/sync_two_stage.sv ***
// Purpose: two flip-flop synchroniser for pins from outside the clock
// Assumes: each bit is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module sync_two_stage #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule : sync_two_stage
`default_nettype wire

// *** shared/sar_adc_pkg.sv ***
// Purpose: shared constants of the approximation converter control block
// Assumes: 100 MHz system clock, 32-bit classic Wishbone register access
// Notes:   register map, field positions, reset values and step timing
package sar_adc_pkg;

    // system and converter step rates
    localparam int unsigned MCLK_HZ      = 100_000_000;
    localparam int unsigned CONV_CLK_HZ  = 640_000;
    // one converter clock period in system cycles, rounded down, at least 1
    localparam int unsigned STEP_CYCLES  =
        (MCLK_HZ / CONV_CLK_HZ) < 1 ? 1 : (MCLK_HZ / CONV_CLK_HZ);

    // widths
    localparam int unsigned RESULT_W     = 8;
    localparam int unsigned CHAN_W       = 4;
    localparam int unsigned CHAN_N       = 16;
    localparam int unsigned ADR_W        = 8;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] STATUS_OFS    = 8'h04;
    localparam logic [7:0] RESULT_OFS    = 8'h08;

    // control register fields
    localparam int unsigned CTRL_TRIG_BIT = 0;
    localparam int unsigned CTRL_FREE_BIT = 1;
    localparam int unsigned CTRL_OE_BIT   = 2;
    localparam logic [2:0]  CTRL_RESET    = 3'h0;

    // status register fields
    localparam int unsigned STAT_DONE_BIT = 0;
    localparam int unsigned STAT_BUSY_BIT = 1;
    localparam int unsigned STAT_GATE_BIT = 2;
    localparam int unsigned STAT_CHAN_LSB = 4;

    // reset values and the first trial mask
    localparam logic [7:0]  RESULT_RESET = 8'h00;
    localparam logic [3:0]  CHAN_RESET   = 4'h0;
    localparam logic        DONE_RESET   = 1'b1;
    localparam logic [7:0]  MSB_MASK     = 8'h80;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_RUN   = 2'b10,
        ST_LATCH = 2'b11
    } seq_state_e;

endpackage : sar_adc_pkg
